// [rtl/tcm_regs.svh]
`ifndef TCM_REGS_SVH
`define TCM_REGS_SVH

// Register byte offsets.
`define TCM_CTRL_OFS 8'h00
`define TCM_STAT_OFS 8'h04
`define TCM_IRQ_STAT_OFS 8'h08
`define TCM_IRQ_MASK_OFS 8'h0c

// Control register fields and reset value.
`define TCM_CTRL_ROLE_LSB 0
`define TCM_CTRL_CUR_LSB 2
`define TCM_CTRL_VCONN_BIT 4
`define TCM_CTRL_MASK 32'h0000_001f
`define TCM_CTRL_RST 32'h0000_0010

// Status register fields.
`define TCM_STAT_ATT_BIT 0
`define TCM_STAT_FLIP_BIT 1
`define TCM_STAT_SRC_BIT 2
`define TCM_STAT_SNK_BIT 3
`define TCM_STAT_AUDIO_BIT 4
`define TCM_STAT_CUR_LSB 5
`define TCM_STAT_FAULT_BIT 7
`define TCM_STAT_REGMODE_BIT 8
`define TCM_STAT_ADDR6_BIT 9
`define TCM_STAT_LOWPWR_BIT 10
`define TCM_STAT_VBUS_BIT 11

// Interrupt status and mask fields.
`define TCM_IRQ_ATTACH_BIT 0
`define TCM_IRQ_DETACH_BIT 1
`define TCM_IRQ_CUR_BIT 2
`define TCM_IRQ_AUDIO_BIT 3
`define TCM_IRQ_FAULT_BIT 4
`define TCM_IRQ_MASK 32'h0000_001f
`define TCM_IRQ_MASK_RST 32'h0000_001f

// Tri-level strap codes from the pad detector.
`define TCM_TRI_FLOAT 2'h0
`define TCM_TRI_HIGH 2'h1
`define TCM_TRI_LOW 2'h2

// Synchroniser reset value; the enable bit resets to disabled.
`define TCM_PIN_SYNC_RST 8'h10

// AXI responses.
`define TCM_RESP_OKAY 2'h0
`define TCM_RESP_SLVERR 2'h2

// Timing.
`define TCM_CLK_MHZ 250
`define TCM_DEBOUNCE_US 100

`endif

// [rtl/tcm_pkg.sv]
package tcm_pkg;

   typedef enum logic [1:0] {TCM_ROLE_DRP, TCM_ROLE_SRC, TCM_ROLE_SNK} tcm_role_t;

   typedef enum logic [1:0] {TCM_CUR_DEF, TCM_CUR_MED, TCM_CUR_HIGH} tcm_cur_t;

   typedef enum logic [2:0] {ST_OFF, ST_UNATT, ST_SRC, ST_SNK, ST_AUDIO} tcm_state_t;

   // Comparator results on the CC lines.
   typedef struct packed {
      logic rd_cc1;
      logic rd_cc2;
      logic rp_cc1;
      logic rp_cc2;
      tcm_cur_t rp_level;
      logic audio;
   } tcm_cc_t;

endpackage : tcm_pkg

// [rtl/tcm_ctrl.sv]
`timescale 1ns/1ps
`include "tcm_regs.svh"

// Functional notes
// - Bus-id strap picks pin or register control.
// - Pin mode: role strap sets port role.
// - Sink in pin mode encodes partner current.
// - Register mode: interrupt pin low on changes.
// - Pin mode: shared pin flags audio accessory.
// - Attach flag low when attached as host.
// - Enable input active low; high disables.
// - Mux position follows detected plug orientation.
// - Power unused CC; cut on fault.
// - Host in pin mode advertises default current.
// - Register mode selects three advertised currents.
// - Attach flag also works in register mode.
module tcm_ctrl
   import tcm_pkg::*;
#(
   parameter int DEBOUNCE_CYC = `TCM_DEBOUNCE_US * `TCM_CLK_MHZ
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Straps, enable and sense pins
   input wire logic [1:0] addr_strap,
   input wire logic [1:0] role_strap,
   input wire logic chip_enable_n,
   input wire logic bus_power_sense,
   input wire logic vconn_ocp,
   input wire logic vconn_ovp,
   input wire tcm_cc_t cc_raw,
   // Analog front-end controls
   output logic present_rp,
   output logic present_rd,
   output tcm_cur_t rp_level,
   output logic vconn_cc1,
   output logic vconn_cc2,
   output logic mux_on,
   output logic mux_pos2,
   output logic low_power,
   output logic i2c_enable,
   output logic i2c_addr_bit6,
   // Open-drain pins
   output logic attach_flag_n_o,
   output logic attach_flag_n_oe_n,
   output logic current_detect_hi_o,
   output logic current_detect_hi_oe_n,
   output logic current_detect_lo_o,
   output logic current_detect_lo_oe_n,
   output logic change_irq_n_o,
   output logic change_irq_n_oe_n,
   // Interrupt
   output logic irq
);

   localparam int DEB_W = $clog2(DEBOUNCE_CYC + 1);

   function automatic tcm_role_t decode_role(input logic [1:0] code);
      decode_role = (code == `TCM_TRI_HIGH) ? TCM_ROLE_SRC :
                    (code == `TCM_TRI_LOW) ? TCM_ROLE_SNK : TCM_ROLE_DRP;
   endfunction : decode_role

   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      apply_strb = res;
   endfunction : apply_strb

   // Pin synchronisers.
   logic [7:0] pins_s1;
   logic [7:0] pins_s2;
   tcm_cc_t cc_s1;
   tcm_cc_t cc_sync;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pins_s1 <= `TCM_PIN_SYNC_RST;
         pins_s2 <= `TCM_PIN_SYNC_RST;
         cc_s1 <= '0;
         cc_sync <= '0;
      end
      else
      begin
         pins_s1 <= {bus_power_sense, vconn_ovp, vconn_ocp, chip_enable_n, role_strap, addr_strap};
         pins_s2 <= pins_s1;
         cc_s1 <= cc_raw;
         cc_sync <= cc_s1;
      end
   end

   wire [1:0] addr_s = pins_s2[1:0];
   wire [1:0] role_s = pins_s2[3:2];
   wire en_n_s = pins_s2[4];
   wire fault_in = pins_s2[5] | pins_s2[6];
   wire vbus_s = pins_s2[7];

   logic [31:0] ctrl;
   logic [31:0] irq_mask;
   logic [4:0] irq_status;

   wire reg_mode = (addr_s == `TCM_TRI_HIGH) || (addr_s == `TCM_TRI_LOW);
   wire pin_mode = !reg_mode;
   wire enabled = !en_n_s;
   wire tcm_role_t role = pin_mode ? decode_role(role_s) :
                                     decode_role(ctrl[`TCM_CTRL_ROLE_LSB +: 2]);
   wire [1:0] cur_sel = ctrl[`TCM_CTRL_CUR_LSB +: 2];
   wire tcm_cur_t reg_cur = (cur_sel == 2'h1) ? TCM_CUR_MED :
                            (cur_sel == 2'h2) ? TCM_CUR_HIGH : TCM_CUR_DEF;
   wire tcm_cur_t adv_cur = pin_mode ? TCM_CUR_DEF : reg_cur;

   // A change restarts the count, so a bouncing contact never reaches the state machine.
   tcm_cc_t cc_last;
   tcm_cc_t cc_stable;
   logic [DEB_W-1:0] deb_cnt;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cc_last <= '0;
         cc_stable <= '0;
         deb_cnt <= '0;
      end
      else
      begin
         cc_last <= cc_sync;
         if (cc_sync != cc_last || cc_sync == cc_stable)
         begin
            deb_cnt <= '0;
         end
         else if (deb_cnt == DEB_W'(DEBOUNCE_CYC))
         begin
            cc_stable <= cc_sync;
            deb_cnt <= '0;
         end
         else
         begin
            deb_cnt <= deb_cnt + 1'b1;
         end
      end
   end

   // A dual-role port alternates its pull while unattached to find either partner.
   logic drp_rp_phase;
   logic [DEB_W-1:0] tog_cnt;
   tcm_state_t state;
   tcm_state_t next_state;
   logic flipped;
   logic next_flipped;
   logic vconn_fault;
   tcm_cur_t cur_det;

   wire offer_rp = (role == TCM_ROLE_SRC) || (role == TCM_ROLE_DRP && drp_rp_phase);
   wire offer_rd = (role == TCM_ROLE_SNK) || (role == TCM_ROLE_DRP && !drp_rp_phase);
   wire sink_seen = cc_stable.rp_cc1 ^ cc_stable.rp_cc2;
   wire src_seen = cc_stable.rd_cc1 ^ cc_stable.rd_cc2;

   always_comb
   begin
      next_state = state;
      next_flipped = flipped;
      unique case (state)
         ST_OFF:
            next_state = ST_UNATT;
         ST_UNATT:
            if (cc_stable.audio)
            begin
               next_state = ST_AUDIO;
            end
            else if (offer_rd && sink_seen)
            begin
               next_state = ST_SNK;
               next_flipped = cc_stable.rp_cc2;
            end
            else if (offer_rp && src_seen)
            begin
               next_state = ST_SRC;
               next_flipped = cc_stable.rd_cc2;
            end
         ST_SRC:
            if (!(cc_stable.rd_cc1 | cc_stable.rd_cc2))
            begin
               next_state = ST_UNATT;
            end
         ST_SNK:
            if (!(cc_stable.rp_cc1 | cc_stable.rp_cc2))
            begin
               next_state = ST_UNATT;
            end
         ST_AUDIO:
            if (!cc_stable.audio)
            begin
               next_state = ST_UNATT;
            end
      endcase
      if (!enabled)
      begin
         next_state = ST_OFF;
      end
   end

   wire in_src = (state == ST_SRC);
   wire in_snk = (state == ST_SNK);
   wire attached = in_src || in_snk || (state == ST_AUDIO);
   wire next_attached = (next_state == ST_SRC) || (next_state == ST_SNK) || (next_state == ST_AUDIO);
   wire next_fault = (next_state == ST_SRC) && (vconn_fault || fault_in);
   wire tcm_cur_t next_cur = (next_state == ST_SNK) ? cc_stable.rp_level : TCM_CUR_DEF;
   wire vconn_want = in_src && !vconn_fault && (pin_mode || ctrl[`TCM_CTRL_VCONN_BIT]);

   // Hardware events; the set term wins over a same-cycle software clear.
   wire [4:0] evt = {next_fault && !vconn_fault,
                     (next_state == ST_AUDIO) != (state == ST_AUDIO),
                     next_cur != cur_det,
                     attached && !next_attached,
                     !attached && next_attached};

   wire [31:0] status_word = {20'h0, vbus_s, low_power, i2c_addr_bit6, reg_mode, vconn_fault,
                              cur_det, state == ST_AUDIO, in_snk, in_src, flipped, attached};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_OFF;
         flipped <= 1'b0;
         vconn_fault <= 1'b0;
         cur_det <= TCM_CUR_DEF;
         drp_rp_phase <= 1'b0;
         tog_cnt <= '0;
      end
      else
      begin
         state <= next_state;
         flipped <= next_flipped;
         vconn_fault <= next_fault;
         cur_det <= next_cur;
         if (state != ST_UNATT || role != TCM_ROLE_DRP || tog_cnt == DEB_W'(DEBOUNCE_CYC))
         begin
            tog_cnt <= '0;
            drp_rp_phase <= (state == ST_UNATT && role == TCM_ROLE_DRP) ? !drp_rp_phase : 1'b0;
         end
         else
         begin
            tog_cnt <= tog_cnt + 1'b1;
         end
      end
   end

   // Registered pin and front-end outputs; attach and current pins release while disabled, the change pin follows irq in register mode.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         present_rp <= 1'b0;
         present_rd <= 1'b0;
         rp_level <= TCM_CUR_DEF;
         vconn_cc1 <= 1'b0;
         vconn_cc2 <= 1'b0;
         mux_on <= 1'b0;
         mux_pos2 <= 1'b0;
         low_power <= 1'b1;
         i2c_enable <= 1'b0;
         i2c_addr_bit6 <= 1'b0;
         attach_flag_n_oe_n <= 1'b1;
         current_detect_hi_oe_n <= 1'b1;
         current_detect_lo_oe_n <= 1'b1;
         change_irq_n_oe_n <= 1'b1;
         irq <= 1'b0;
      end
      else
      begin
         present_rp <= enabled && (in_src || (state == ST_UNATT && offer_rp));
         present_rd <= enabled && (in_snk || (state == ST_UNATT && offer_rd));
         rp_level <= adv_cur;
         vconn_cc1 <= vconn_want && flipped;
         vconn_cc2 <= vconn_want && !flipped;
         mux_on <= in_src || in_snk;
         mux_pos2 <= flipped;
         low_power <= !enabled;
         i2c_enable <= reg_mode;
         i2c_addr_bit6 <= (addr_s == `TCM_TRI_HIGH);
         attach_flag_n_oe_n <= !in_src;
         current_detect_lo_oe_n <= !(pin_mode && in_snk && cur_det != TCM_CUR_DEF);
         current_detect_hi_oe_n <= !(pin_mode && in_snk && cur_det == TCM_CUR_HIGH);
         change_irq_n_oe_n <= reg_mode ? !irq : !(enabled && state == ST_AUDIO);
         irq <= |(irq_status & irq_mask[4:0]);
      end
   end

   assign attach_flag_n_o = 1'b0;
   assign current_detect_hi_o = 1'b0;
   assign current_detect_lo_o = 1'b0;
   assign change_irq_n_o = 1'b0;

   // AXI4-Lite: address and data are held separately and the write fires once both are in.
   logic aw_have;
   logic w_have;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   assign s_axi_awready = !aw_have;
   assign s_axi_wready = !w_have;
   assign s_axi_arready = !s_axi_rvalid;

   wire do_write = aw_have && w_have && !s_axi_bvalid;
   wire [31:0] w_merged_ctrl = apply_strb(ctrl, w_data, w_strb) & `TCM_CTRL_MASK;
   wire [31:0] w_merged_mask = apply_strb(irq_mask, w_data, w_strb) & `TCM_IRQ_MASK;
   wire [31:0] w_clear = apply_strb(32'h0, w_data, w_strb);
   wire wr_ctrl = do_write && aw_addr == `TCM_CTRL_OFS;
   wire wr_mask = do_write && aw_addr == `TCM_IRQ_MASK_OFS;
   wire wr_istat = do_write && aw_addr == `TCM_IRQ_STAT_OFS;
   wire wr_ok = wr_ctrl || wr_mask || wr_istat || (aw_addr == `TCM_STAT_OFS);
   wire [4:0] irq_clr = wr_istat ? w_clear[4:0] : 5'h0;
   wire [4:0] next_irq_status = (irq_status & ~irq_clr) | evt;

   wire rd_ok = (s_axi_araddr == `TCM_CTRL_OFS) || (s_axi_araddr == `TCM_STAT_OFS) ||
                (s_axi_araddr == `TCM_IRQ_STAT_OFS) || (s_axi_araddr == `TCM_IRQ_MASK_OFS);
   wire [31:0] rd_word = (s_axi_araddr == `TCM_CTRL_OFS) ? ctrl :
                         (s_axi_araddr == `TCM_STAT_OFS) ? status_word :
                         (s_axi_araddr == `TCM_IRQ_STAT_OFS) ? {27'h0, irq_status} :
                         (s_axi_araddr == `TCM_IRQ_MASK_OFS) ? irq_mask : 32'h0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TCM_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `TCM_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         ctrl <= `TCM_CTRL_RST;
         irq_mask <= `TCM_IRQ_MASK_RST;
         irq_status <= 5'h0;
      end
      else
      begin
         if (s_axi_awvalid && !aw_have)
         begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (do_write)
         begin
            aw_have <= 1'b0;
         end
         if (s_axi_wvalid && !w_have)
         begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_write)
         begin
            w_have <= 1'b0;
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `TCM_RESP_OKAY : `TCM_RESP_SLVERR;
         end
         else if (s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
         if (wr_ctrl)
         begin
            ctrl <= w_merged_ctrl;
         end
         if (wr_mask)
         begin
            irq_mask <= w_merged_mask;
         end
         irq_status <= next_irq_status;
      end
   end

   property p_attach_flag;
      @(posedge aclk) disable iff (!aresetn)
      attach_flag_n_oe_n == !$past(in_src);
   endproperty
   a_attach_flag: assert property (p_attach_flag) else $error("attach flag wrong");

   property p_irq_pin;
      @(posedge aclk) disable iff (!aresetn)
      (reg_mode && irq) |=> !change_irq_n_oe_n;
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not low");

   property p_audio_pin;
      @(posedge aclk) disable iff (!aresetn)
      (pin_mode && enabled && state == ST_AUDIO) |=> !change_irq_n_oe_n;
   endproperty
   a_audio_pin: assert property (p_audio_pin) else $error("audio flag not low");

   property p_cur_med;
      @(posedge aclk) disable iff (!aresetn)
      (pin_mode && in_snk && cur_det == TCM_CUR_MED) |=>
         (!current_detect_lo_oe_n && current_detect_hi_oe_n);
   endproperty
   a_cur_med: assert property (p_cur_med) else $error("medium current code wrong");

   property p_host_default;
      @(posedge aclk) disable iff (!aresetn)
      (pin_mode && in_src) |=> (rp_level == TCM_CUR_DEF);
   endproperty
   a_host_default: assert property (p_host_default) else $error("host not default");

   property p_mux_pos;
      @(posedge aclk) disable iff (!aresetn)
      (in_src || in_snk) |=> (mux_on && mux_pos2 == $past(flipped));
   endproperty
   a_mux_pos: assert property (p_mux_pos) else $error("mux position wrong");

   property p_vconn_cut;
      @(posedge aclk) disable iff (!aresetn)
      vconn_fault |=> (!vconn_cc1 && !vconn_cc2);
   endproperty
   a_vconn_cut: assert property (p_vconn_cut) else $error("vconn on during fault");

   property p_disable;
      @(posedge aclk) disable iff (!aresetn)
      en_n_s [*2] |=> (state == ST_OFF && low_power && attach_flag_n_oe_n);
   endproperty
   a_disable: assert property (p_disable) else $error("not disabled");

   property p_debounce;
      @(posedge aclk) disable iff (!aresetn)
      (cc_sync != cc_last) |=> $stable(cc_stable);
   endproperty
   a_debounce: assert property (p_debounce) else $error("bounce reached state");

   property p_addr_bit6;
      @(posedge aclk) disable iff (!aresetn)
      (addr_s == `TCM_TRI_LOW) [*2] |-> (i2c_enable && !i2c_addr_bit6);
   endproperty
   a_addr_bit6: assert property (p_addr_bit6) else $error("address strap decode wrong");

endmodule : tcm_ctrl

// [tb/tcm_partner.sv]
`timescale 1ns/1ps

// Far-end port partner, seen through the CC comparators it would trip.
module tcm_partner
   import tcm_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Comparator results on the CC lines
   output tcm_cc_t cc_raw
);
   initial cc_raw = '0;

   // Kind: 0 nothing, 1/2 pull-up on line 1/2, 3/4 pull-down on line 1/2, 5 audio adapter.
   // A released line trips no comparator, so nothing is left over from the last partner.
   task automatic present(input int kind, input tcm_cur_t lvl);
      tcm_cc_t v;
      v = '0;
      v.rp_cc1 = (kind == 1);
      v.rp_cc2 = (kind == 2);
      v.rd_cc1 = (kind == 3);
      v.rd_cc2 = (kind == 4);
      v.audio = (kind == 5);
      v.rp_level = (kind == 1 || kind == 2) ? lvl : TCM_CUR_DEF;
      @(posedge aclk);
      cc_raw <= v;
   endtask : present
endmodule : tcm_partner

// [tb/typec_port_role_and_mux_control_tb_top.sv]
`timescale 1ns/1ps
`include "tcm_regs.svh"

module typec_port_role_and_mux_control_tb_top
   import tcm_pkg::*;
;
   localparam int DEB = 8;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [1:0] addr_strap = `TCM_TRI_FLOAT, role_strap = `TCM_TRI_FLOAT;
   logic chip_enable_n = 1'b0, bus_power_sense = 1'b0, vconn_ocp = 1'b0, vconn_ovp = 1'b0;
   tcm_cc_t cc_raw;
   tcm_cur_t rp_level;
   logic present_rp, present_rd, vconn_cc1, vconn_cc2, mux_on, mux_pos2, low_power;
   logic i2c_enable, i2c_addr_bit6, irq;
   logic attach_oe_n, cur_hi_oe_n, cur_lo_oe_n, chg_oe_n;
   int failures = 0, samples_checked = 0, cycles = 0;
   logic [31:0] d;
   logic [1:0] r;

   always #2 aclk = ~aclk;

   tcm_partner u_tcm_partner (.aclk(aclk), .cc_raw(cc_raw));

   tcm_ctrl #(.DEBOUNCE_CYC(DEB)) u_tcm_ctrl (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .addr_strap(addr_strap), .role_strap(role_strap), .chip_enable_n(chip_enable_n),
      .bus_power_sense(bus_power_sense), .vconn_ocp(vconn_ocp), .vconn_ovp(vconn_ovp),
      .cc_raw(cc_raw), .present_rp(present_rp), .present_rd(present_rd),
      .rp_level(rp_level), .vconn_cc1(vconn_cc1), .vconn_cc2(vconn_cc2), .mux_on(mux_on),
      .mux_pos2(mux_pos2), .low_power(low_power), .i2c_enable(i2c_enable),
      .i2c_addr_bit6(i2c_addr_bit6), .attach_flag_n_o(), .attach_flag_n_oe_n(attach_oe_n),
      .current_detect_hi_o(), .current_detect_hi_oe_n(cur_hi_oe_n),
      .current_detect_lo_o(), .current_detect_lo_oe_n(cur_lo_oe_n),
      .change_irq_n_o(), .change_irq_n_oe_n(chg_oe_n), .irq(irq));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict

   // The cycle ceiling is far above the roughly one thousand cycles the scenarios need.
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Inputs are read right after the edge, before the design's updates land.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_read

   // Two sync stages, the debounce window and the output registers fit well inside this.
   task automatic settle();
      repeat (4 * DEB + 8) @(posedge aclk);
   endtask : settle

   task automatic restart(input logic [1:0] a, input logic [1:0] ro);
      u_tcm_partner.present(0, TCM_CUR_DEF);
      addr_strap <= a;
      role_strap <= ro;
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask : restart

   task automatic t_reg_defaults();
      restart(`TCM_TRI_HIGH, `TCM_TRI_FLOAT);
      check("attach after reset", 1'b1, attach_oe_n);
      settle();
      check("bus enable", 1'b1, i2c_enable);
      check("addr bit6 high", 1'b1, i2c_addr_bit6);
      axi_read(`TCM_CTRL_OFS, d, r);
      check("ctrl reset", `TCM_CTRL_RST, d);
      axi_read(`TCM_IRQ_MASK_OFS, d, r);
      check("mask reset", `TCM_IRQ_MASK_RST, d);
      axi_read(8'h10, d, r);
      check("unmapped read resp", `TCM_RESP_SLVERR, r);
      axi_write(8'h14, 32'h1, r);
      check("unmapped write resp", `TCM_RESP_SLVERR, r);
      bus_power_sense <= 1'b1;
      settle();
      axi_read(`TCM_STAT_OFS, d, r);
      check("status mode bits", 32'h3, (d >> 8) & 32'h3);
      check("status power sense", 32'h1, (d >> 11) & 32'h1);
   endtask : t_reg_defaults

   task automatic t_pin_sink();
      restart(`TCM_TRI_FLOAT, `TCM_TRI_LOW);
      settle();
      check("pin mode bus off", 1'b0, i2c_enable);
      check("sink pull-down", 1'b1, present_rd);
      u_tcm_partner.present(2, TCM_CUR_MED);
      repeat (DEB - 4) @(posedge aclk);
      u_tcm_partner.present(0, TCM_CUR_DEF);
      settle();
      check("mux after bounce", 1'b0, mux_on);
      u_tcm_partner.present(2, TCM_CUR_MED);
      settle();
      check("mux on", 1'b1, mux_on);
      check("mux flipped", 1'b1, mux_pos2);
      check("med lo", 1'b0, cur_lo_oe_n);
      check("med hi", 1'b1, cur_hi_oe_n);
      check("attach as sink", 1'b1, attach_oe_n);
      u_tcm_partner.present(2, TCM_CUR_HIGH);
      settle();
      check("high lo", 1'b0, cur_lo_oe_n);
      check("high hi", 1'b0, cur_hi_oe_n);
      u_tcm_partner.present(0, TCM_CUR_DEF);
      settle();
      u_tcm_partner.present(1, TCM_CUR_DEF);
      settle();
      check("mux straight", 1'b0, mux_pos2);
      check("def lo", 1'b1, cur_lo_oe_n);
      check("def hi", 1'b1, cur_hi_oe_n);
   endtask : t_pin_sink

   task automatic t_pin_source();
      restart(`TCM_TRI_FLOAT, `TCM_TRI_HIGH);
      settle();
      check("source pull-up", 1'b1, present_rp);
      u_tcm_partner.present(3, TCM_CUR_DEF);
      settle();
      check("attach as host", 1'b0, attach_oe_n);
      check("host current", TCM_CUR_DEF, rp_level);
      check("cable power", 1'b1, vconn_cc2);
      check("mux straight", 1'b0, mux_pos2);
      vconn_ocp <= 1'b1;
      settle();
      check("cable power cut", 1'b0, vconn_cc2);
      vconn_ocp <= 1'b0;
      u_tcm_partner.present(0, TCM_CUR_DEF);
      settle();
      check("detached", 1'b1, attach_oe_n);
   endtask : t_pin_source

   task automatic t_pin_audio();
      restart(`TCM_TRI_FLOAT, `TCM_TRI_FLOAT);
      u_tcm_partner.present(5, TCM_CUR_DEF);
      settle();
      check("audio flag", 1'b0, chg_oe_n);
      u_tcm_partner.present(0, TCM_CUR_DEF);
      settle();
      check("audio gone", 1'b1, chg_oe_n);
      u_tcm_partner.present(3, TCM_CUR_DEF);
      settle();
      check("dual role as host", 1'b0, attach_oe_n);
      check("dual role pull-up", 1'b1, present_rp);
   endtask : t_pin_audio

   task automatic t_reg_mode();
      restart(`TCM_TRI_LOW, `TCM_TRI_FLOAT);
      settle();
      check("addr bit6 low", 1'b0, i2c_addr_bit6);
      axi_write(`TCM_CTRL_OFS, 32'h19, r);
      u_tcm_partner.present(4, TCM_CUR_DEF);
      settle();
      check("attach reg mode", 1'b0, attach_oe_n);
      check("irq", 1'b1, irq);
      check("irq pin", 1'b0, chg_oe_n);
      check("cable power", 1'b1, vconn_cc1);
      for (int i = 0; i < 3; i++)
      begin
         axi_write(`TCM_CTRL_OFS, 32'h11 | (i << 2), r);
         repeat (8) @(posedge aclk);
         check("advertised current", i, rp_level);
      end
      axi_read(`TCM_IRQ_STAT_OFS, d, r);
      check("attach event", 32'h1, d & 32'h1);
      axi_write(`TCM_IRQ_STAT_OFS, 32'h1f, r);
      repeat (8) @(posedge aclk);
      check("irq cleared", 1'b0, irq);
      check("irq pin released", 1'b1, chg_oe_n);
      axi_write(`TCM_IRQ_MASK_OFS, 32'h0, r);
      u_tcm_partner.present(0, TCM_CUR_DEF);
      settle();
      check("irq masked", 1'b0, irq);
      axi_read(`TCM_IRQ_STAT_OFS, d, r);
      check("detach event", 32'h2, d & 32'h2);
      axi_write(`TCM_IRQ_MASK_OFS, 32'h1f, r);
      repeat (8) @(posedge aclk);
      check("irq unmasked", 1'b1, irq);
   endtask : t_reg_mode

   task automatic t_disable();
      u_tcm_partner.present(3, TCM_CUR_DEF);
      settle();
      check("mux on before disable", 1'b1, mux_on);
      chip_enable_n <= 1'b1;
      settle();
      check("low power", 1'b1, low_power);
      check("mux off", 1'b0, mux_on);
      check("attach released", 1'b1, attach_oe_n);
      chip_enable_n <= 1'b0;
      settle();
      check("active", 1'b0, low_power);
      check("attach again", 1'b0, attach_oe_n);
   endtask : t_disable

   initial
   begin
      t_reg_defaults();
      t_pin_sink();
      t_pin_source();
      t_pin_audio();
      t_reg_mode();
      t_disable();
      give_verdict();
   end
endmodule : typec_port_role_and_mux_control_tb_top
